// File: rtl/plugin_port_consts.vh
/*
  Constants for the plug-on counter mainframe port: measurement timing,
  decade select codes and idle levels of active-low drives.
  Assumes inclusion by bare name from the rtl folder.
*/
`ifndef PLUGIN_PORT_CONSTS_VH
`define PLUGIN_PORT_CONSTS_VH

// ----------------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------------
`define CLK_SYS_MHZ        125
`define TB_1MHZ_FREQ_MHZ   1
// Full period of the 1 MHz feed in system cycles (125)
`define TB_1MHZ_PERIOD     (`CLK_SYS_MHZ / `TB_1MHZ_FREQ_MHZ)
// Low phase of the 1 MHz feed (62); the high phase takes the odd cycle
`define TB_1MHZ_HALF       (`CLK_SYS_MHZ / `TB_1MHZ_FREQ_MHZ / 2)
`define TB_DIV_W           7

// ----------------------------------------------------------------------
// Measurement sequencer
// ----------------------------------------------------------------------
`define SEQ_IDLE           2'b00
`define SEQ_OPEN           2'b01
`define SEQ_RUN            2'b10
`define SEQ_END            2'b11
`define GATE_TIME_W        16
`define GATE_TIME_DEF      16'h00FF
// Close request low time, long enough for a mainframe log pulse to land
`define END_HOLD           16'h0010
`define DECADE_DEF         3'h3
`define RANGE_W            4
`define RANGE_ZERO         4'h0
`define RANGE_ONE          4'h1

// ----------------------------------------------------------------------
// Idle levels of active-low drives
// ----------------------------------------------------------------------
`define LAMPS_DARK         2'h3
`define DP_ALL_OFF         5'h1F

`endif

// File: rtl/digit_select_map.v
/*
  Digit select mapper: returns the digit select code for a scanned
  digit address. Purely combinational.
  Assumes address and mode come from the mainframe scan and
  reach the parent already synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module digit_select_map (
  input  wire [2:0] digit_address,
  input  wire       direct_display,
  input  wire [2:0] digit_offset,
  output wire [2:0] digit_select
);

  // --------------------------------------------------------------------
  // Mapping
  // --------------------------------------------------------------------
  // Direct mode joins lines; else shift by offset (combinational)
  assign digit_select = direct_display ? digit_address
                                       : digit_address + digit_offset;

endmodule

`default_nettype wire

// File: rtl/plugin_counter_mainframe_port.v
/*
  Plug-on side of the counter mainframe connector: drives count signal,
  gated time base, gate open and measure-end requests, decade select,
  annunciators, decimal points, manual clear and digit select.
  Assumes all inputs synchronous to clk_sys; mainframe reset is a high
  level on mainframe_reset; pins are plain push-pull levels.
*/
`timescale 1ns/1ps
`default_nettype none
`include "plugin_port_consts.vh"

module plugin_counter_mainframe_port (
  input  wire                    clk_sys,
  input  wire                    reset_n,
  input  wire                    mainframe_reset,
  input  wire                    input_signal,
  input  wire                    measure_inhibit,
  input  wire                    exponent_n,
  input  wire                    time_base_output,
  input  wire                    start_measure,
  input  wire [`GATE_TIME_W-1:0] gate_time,
  input  wire [2:0]              decade_code,
  input  wire                    freq_units_cpm,
  input  wire [4:0]              dp_select,
  input  wire                    panel_clear_n,
  input  wire                    rear_clear_n,
  input  wire [2:0]              digit_address,
  input  wire                    direct_display,
  input  wire [2:0]              digit_offset,
  output reg                     count_signal_out,
  output wire                    gated_timebase_feed,
  output reg                     gate_open_n,
  output reg                     measure_end_n,
  output reg  [2:0]              decade_select,
  output reg                     tb_1mhz_feed,
  output reg                     unit_lamp_cycles,
  output reg                     unit_lamp_mega,
  output wire                    manual_clear_n,
  output reg                     decimal_point_one,
  output reg                     decimal_point_two,
  output reg                     decimal_point_three,
  output reg                     decimal_point_four,
  output reg                     decimal_point_five,
  output wire [2:0]              digit_select,
  output reg  [`RANGE_W-1:0]     range_steps,
  output wire                    busy
);

  // --------------------------------------------------------------------
  // Internal reset
  // --------------------------------------------------------------------
  // Mainframe reset high clears everything synchronously
  wire clr = mainframe_reset;

  reg  [1:0]              state_q;
  reg  [1:0]              state_d;
  reg  [`GATE_TIME_W-1:0] gate_cnt_q;
  reg  [`TB_DIV_W-1:0]    div_q;
  reg                     tb_gate_q;
  reg                     exp_prev_q;
  reg  [4:0]              dp_q;
  reg  [1:0]              lamp_q;

  // --------------------------------------------------------------------
  // Count signal and gated time base
  // --------------------------------------------------------------------
  // Register the conditioned input toward the mainframe counter
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_signal_out <= 1'b0;
    end else if (clr) begin
      count_signal_out <= 1'b0;
    end else begin
      count_signal_out <= input_signal;
    end
  end

  // Time base reaches mainframe only while the gate window is on
  assign gated_timebase_feed = tb_gate_q & time_base_output;

  // Free 1 MHz feed; uneven phase split keeps the period exact
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_q        <= {`TB_DIV_W{1'b0}};
      tb_1mhz_feed <= 1'b0;
    end else if (clr) begin
      div_q        <= {`TB_DIV_W{1'b0}};
      tb_1mhz_feed <= 1'b0;
    end else if (div_q == (tb_1mhz_feed ? `TB_1MHZ_PERIOD - `TB_1MHZ_HALF - 1
                                        : `TB_1MHZ_HALF - 1)) begin
      div_q        <= {`TB_DIV_W{1'b0}};
      tb_1mhz_feed <= ~tb_1mhz_feed;
    end else begin
      div_q        <= div_q + 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Measurement sequencer
  // --------------------------------------------------------------------
  // Next state: open gate, run gate time, release close, wait display
  always @* begin
    state_d = state_q;
    case (state_q)
      `SEQ_IDLE: begin
        // New start only once the mainframe display cycle is over
        if (start_measure && manual_clear_n && measure_inhibit) begin
          state_d = `SEQ_OPEN;
        end
      end
      `SEQ_OPEN: begin
        state_d = `SEQ_RUN;
      end
      `SEQ_RUN: begin
        if (gate_cnt_q == {`GATE_TIME_W{1'b0}}) begin
          state_d = `SEQ_END;
        end
      end
      `SEQ_END: begin
        // Hold the close request a fixed time, then release it
        if (gate_cnt_q == {`GATE_TIME_W{1'b0}}) begin
          state_d = `SEQ_IDLE;
        end
      end
      default: begin
        state_d = `SEQ_IDLE;
      end
    endcase
  end

  // State, gate counter and active-low gate drives
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q       <= `SEQ_IDLE;
      gate_cnt_q    <= `GATE_TIME_DEF;
      gate_open_n   <= 1'b1;
      measure_end_n <= 1'b1;
      tb_gate_q     <= 1'b0;
    end else if (clr || !manual_clear_n) begin
      state_q       <= `SEQ_IDLE;
      gate_cnt_q    <= `GATE_TIME_DEF;
      gate_open_n   <= 1'b1;
      measure_end_n <= 1'b1;
      tb_gate_q     <= 1'b0;
    end else begin
      state_q       <= state_d;
      // Pulse low for one cycle to force main gate open
      gate_open_n   <= !(state_d == `SEQ_OPEN);
      // Low permits close; release high starts display cycle
      measure_end_n <= !(state_d == `SEQ_END);
      tb_gate_q     <= (state_d == `SEQ_RUN);
      if (state_d == `SEQ_OPEN) begin
        gate_cnt_q  <= gate_time;
      end else if (state_q == `SEQ_RUN && state_d == `SEQ_END) begin
        gate_cnt_q  <= `END_HOLD;
      end else if ((state_q == `SEQ_RUN || state_q == `SEQ_END) &&
                   gate_cnt_q != {`GATE_TIME_W{1'b0}}) begin
        gate_cnt_q  <= gate_cnt_q - 1'b1;
      end
    end
  end

  assign busy = (state_q != `SEQ_IDLE);

  // --------------------------------------------------------------------
  // Auto-range step count
  // --------------------------------------------------------------------
  // Count falling edges of inverted log pulses while busy (open, run and end states)
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      exp_prev_q  <= 1'b1;
      range_steps <= `RANGE_ZERO;
    end else if (clr) begin
      exp_prev_q  <= 1'b1;
      range_steps <= `RANGE_ZERO;
    end else begin
      exp_prev_q <= exponent_n;
      if (state_d == `SEQ_OPEN) begin
        range_steps <= `RANGE_ZERO;
      end else if (exp_prev_q && !exponent_n && busy) begin
        range_steps <= range_steps + `RANGE_ONE;
      end
    end
  end

  // --------------------------------------------------------------------
  // Decade select, annunciators, decimal points
  // --------------------------------------------------------------------
  // Registered display drives; lamps and decimal points active low
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      decade_select <= `DECADE_DEF;
      lamp_q        <= `LAMPS_DARK;
      dp_q          <= `DP_ALL_OFF;
    end else if (clr) begin
      decade_select <= `DECADE_DEF;
      lamp_q        <= `LAMPS_DARK;
      dp_q          <= `DP_ALL_OFF;
    end else begin
      decade_select <= decade_code;
      lamp_q        <= {~freq_units_cpm, freq_units_cpm};
      dp_q          <= ~dp_select;
    end
  end

  // Fan out to individual pins
  always @* begin
    unit_lamp_cycles    = lamp_q[0];
    unit_lamp_mega      = lamp_q[1];
    decimal_point_one   = dp_q[0];
    decimal_point_two   = dp_q[1];
    decimal_point_three = dp_q[2];
    decimal_point_four  = dp_q[3];
    decimal_point_five  = dp_q[4];
  end

  // --------------------------------------------------------------------
  // Manual clear and digit select
  // --------------------------------------------------------------------
  // Either source pulls the clear low
  assign manual_clear_n = panel_clear_n & rear_clear_n;

  digit_select_map u_map (
    .digit_address  (digit_address),
    .direct_display (direct_display),
    .digit_offset   (digit_offset),
    .digit_select   (digit_select)
  );

endmodule

`default_nettype wire

// File: verif/port_monitor.sv
/* Checker on the plug-on port outputs.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module port_monitor (
  input wire       clk_sys,
  input wire       reset_n,
  input wire       mainframe_reset,
  input wire       input_signal,
  input wire       time_base_output,
  input wire [2:0] decade_code,
  input wire       freq_units_cpm,
  input wire [4:0] dp_select,
  input wire       panel_clear_n,
  input wire       rear_clear_n,
  input wire [2:0] digit_address,
  input wire       direct_display,
  input wire       count_signal_out,
  input wire       gated_timebase_feed,
  input wire       gate_open_n,
  input wire       measure_end_n,
  input wire [2:0] decade_select,
  input wire       unit_lamp_cycles,
  input wire       unit_lamp_mega,
  input wire       manual_clear_n,
  input wire       decimal_point_one,
  input wire       decimal_point_two,
  input wire       decimal_point_three,
  input wire       decimal_point_four,
  input wire       decimal_point_five,
  input wire [2:0] digit_select,
  input wire [3:0] range_steps,
  input wire       busy
);
  logic       live_q;
  logic [4:0] dp_lines;
  // Previous cycle was free of both resets
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) live_q <= 1'b0;
    else live_q <= !mainframe_reset;
  end
  assign dp_lines = {decimal_point_five, decimal_point_four, decimal_point_three,
                     decimal_point_two, decimal_point_one};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_count_follows: assert property (live_q |-> count_signal_out == $past(input_signal))
    else $error("count output not a copy of input");
  a_feed_gated: assert property (gated_timebase_feed |-> time_base_output)
    else $error("feed high without time base");
  a_open_pulse: assert property ($fell(gate_open_n) |=> gate_open_n)
    else $error("gate open pulse too long");
  a_reset_idle: assert property (mainframe_reset |=> gate_open_n && measure_end_n
    && !busy && range_steps == 4'h0) else $error("state kept through reset");
  a_end_shut: assert property (!measure_end_n |-> !gated_timebase_feed)
    else $error("feed open at measure end");
  a_decade_copy: assert property (live_q |-> decade_select == $past(decade_code))
    else $error("decade select wrong");
  a_lamp_level: assert property (live_q |-> unit_lamp_cycles == $past(freq_units_cpm)
    && unit_lamp_mega == !$past(freq_units_cpm)) else $error("lamp level wrong");
  a_clear_pass: assert property (manual_clear_n == (panel_clear_n & rear_clear_n))
    else $error("manual clear wrong");
  a_dp_level: assert property (live_q |-> dp_lines == ~$past(dp_select))
    else $error("decimal point level wrong");
  a_digit_direct: assert property (direct_display |-> digit_select == digit_address)
    else $error("digit select differs");
  c_open: cover property ($fell(gate_open_n));
  c_end: cover property ($fell(measure_end_n));
  c_steps: cover property (range_steps == 4'h3);
endmodule
bind plugin_counter_mainframe_port port_monitor i_mon (.*);
`default_nettype wire

// File: verif/mainframe_model.sv
/* Behavioural mainframe: cycle indicator, exponent pulses, time base, scan.
   Assumes the plug-on drives gate open and measure end requests. */
`timescale 1ns/1ps
`default_nettype none
module mainframe_model (
  input  wire       clk_sys,
  input  wire       gate_open_n,
  input  wire       measure_end_n,
  input  wire [2:0] decade_select,
  output reg        measure_inhibit,
  output reg        exponent_n,
  output reg        time_base_output,
  output reg  [2:0] digit_address,
  output reg  [3:0] pulses_made
);
  reg       gate_q, end_q, half_char, transfer_n, print_n;
  reg [2:0] tick_q;
  reg [3:0] disp_q;
  wire      log_tick = tick_q == 3'h7;
  wire      fire = gate_q && log_tick && pulses_made < 4'h3 && measure_end_n;
  wire      disp_start = measure_end_n && !end_q;
  initial begin
    {gate_q, tick_q, time_base_output, digit_address, pulses_made, disp_q} = 16'h0000;
    {measure_inhibit, exponent_n, end_q, half_char, transfer_n, print_n} = 6'h3F;
  end
  // All mainframe lines change after the falling edge
  always @(negedge clk_sys) begin
    // Decade zero toggles every cycle, the others every second cycle
    if (decade_select == 3'h0 || tick_q[0]) time_base_output <= ~time_base_output;
    tick_q <= tick_q + 3'h1;
    half_char <= tick_q[2];
    if (tick_q == 3'h0) digit_address <= digit_address + 3'h1;
    if (!gate_open_n) {gate_q, pulses_made} <= 5'h10;
    else if (gate_q && log_tick && !measure_end_n) gate_q <= 1'b0;
    else if (fire) pulses_made <= pulses_made + 4'h1;
    exponent_n <= !fire;
    end_q <= measure_end_n;
    transfer_n <= !disp_start;
    print_n <= !disp_start;
    // Display cycle opens on the rising close request, then lasts 8 cycles
    if (disp_start) begin
      disp_q <= 4'h8;
      measure_inhibit <= 1'b0;
    end else if (disp_q != 4'h0) begin
      disp_q <= disp_q - 4'h1;
      measure_inhibit <= disp_q == 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: verif/plugin_counter_mainframe_port_bench.sv
/* Testbench for the plug-on port.
   Assumes the mainframe model sits on the far side. */
`timescale 1ns/1ps
`default_nettype none
`include "plugin_port_consts.vh"
module plugin_counter_mainframe_port_bench;
  logic clk_sys = 0, reset_n = 0, mainframe_reset = 0, input_signal = 0;
  logic start_measure = 0, freq_units_cpm = 0, panel_clear_n = 1, rear_clear_n = 1;
  logic direct_display = 1;
  logic [15:0] gate_time = 16'h0040;
  logic [4:0] dp_select = 0;
  logic [2:0] decade_code = 0, digit_offset = 0, sel_exp;
  wire measure_inhibit, exponent_n, time_base_output, count_signal_out;
  wire gated_timebase_feed, gate_open_n, measure_end_n, tb_1mhz_feed, busy;
  wire unit_lamp_cycles, unit_lamp_mega, manual_clear_n, decimal_point_one;
  wire decimal_point_two, decimal_point_three, decimal_point_four, decimal_point_five;
  wire [2:0] digit_address, digit_select, decade_select;
  wire [3:0] range_steps, pulses_made;
  integer error_cnt = 0, checks_done = 0, cyc = 0, n, f;
  plugin_counter_mainframe_port i_dut (.*);
  mainframe_model i_mf (.*);
  always #4 clk_sys = ~clk_sys;
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // Cut a hang short
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      end_sim;
    end
  end
  task t_static;
    for (n = 0; n < 8; n = n + 1) begin
      @(negedge clk_sys);
      {rear_clear_n, panel_clear_n, freq_units_cpm} = n[2:0];
      input_signal = n[0];
      decade_code = n[2:0];
      direct_display = ~n[0];
      digit_offset = n[2:0] + 3'h1;
      dp_select = 5'h01 << (n % 5);
      @(negedge clk_sys);
      chk(decade_select, n[2:0]);
      chk({decimal_point_five, decimal_point_four, decimal_point_three,
           decimal_point_two, decimal_point_one}, ~dp_select & 5'h1F);
      chk({unit_lamp_cycles, unit_lamp_mega}, {n[0], ~n[0]});
      chk(manual_clear_n, n[1] & n[2]);
      chk(count_signal_out, n[0]);
      sel_exp = digit_address + digit_offset;
      chk(digit_select, direct_display ? digit_address : sel_exp);
    end
  endtask
  task t_measure;
    begin
      @(negedge clk_sys) {panel_clear_n, rear_clear_n, start_measure} = 3'b111;
      @(negedge clk_sys) start_measure = 0;
      for (n = 0; n < 4 && gate_open_n !== 1'b0; n = n + 1) @(negedge clk_sys);
      chk(gate_open_n, 0);
      for (f = 0, n = 0; n < 400 && measure_end_n !== 1'b0; n = n + 1) begin
        @(negedge clk_sys);
        if (gated_timebase_feed === 1'b1) f = f + 1;
      end
      chk(f != 0, 1);
      chk(measure_end_n, 0);
      chk(range_steps, pulses_made);
      chk(pulses_made, 3);
      for (n = 0; n < 40 && busy !== 1'b0; n = n + 1) @(negedge clk_sys);
      chk({busy, measure_end_n}, 2'b01);
    end
  endtask
  task t_refuse_reset;
    begin
      repeat (10) @(negedge clk_sys);
      {panel_clear_n, start_measure} = 2'b01;
      repeat (2) @(negedge clk_sys);
      chk(busy, 0);
      {panel_clear_n, start_measure} = 2'b11;
      repeat (6) @(negedge clk_sys);
      chk(busy, 1);
      {mainframe_reset, start_measure} = 2'b10;
      @(negedge clk_sys);
      chk({gate_open_n, measure_end_n, busy, range_steps}, 7'h60);
      mainframe_reset = 0;
    end
  endtask
  task t_1mhz;
    begin
      for (n = 0; n < 200 && tb_1mhz_feed !== 1'b1; n = n + 1) @(negedge clk_sys);
      for (n = 0; n < 200 && tb_1mhz_feed !== 1'b0; n = n + 1) @(negedge clk_sys);
      for (n = 0; n < 200 && tb_1mhz_feed !== 1'b1; n = n + 1) @(negedge clk_sys);
      chk(n, `TB_1MHZ_HALF);
      for (f = 0; f < 200 && tb_1mhz_feed !== 1'b0; f = f + 1) @(negedge clk_sys);
      chk(n + f, `TB_1MHZ_PERIOD);
    end
  endtask
  initial begin
    repeat (2) @(negedge clk_sys);
    chk({gate_open_n, measure_end_n, unit_lamp_cycles, unit_lamp_mega, busy}, 5'h1E);
    chk(decade_select, `DECADE_DEF);
    @(negedge clk_sys) reset_n = 1;
    t_static;
    t_measure;
    t_refuse_reset;
    t_1mhz;
    end_sim;
  end
endmodule
`default_nettype wire
